// >>> shared/host_port_consts.vh
// What this block does
// - Reset pin clears both DAC registers to zero regardless of conversion clock.
// - Reset pin also returns the conversion-complete flag high.
// - Conversion-complete flag goes low once a conversion result is latched.
// - Flag returns high on rising edge of device select or read strobe.
// - Low pulse on reset pin forces flag high even without a read.
// - Selector low writes first DAC register, high writes second on dual parts.
// - A DAC write needs select active with the write strobe and valid selector.
// - Bus data is captured into the addressed register on write strobe rising edge.
// - Data bus is eight bits, line 7 most significant, line 0 least.
// - Conversion timed by external clock when chosen, else internal oscillator.
// - Binary coding for single supply, twos complement for negative supply, both ways.
// - Host asserts read strobe with select to get the result on the bus.
// - Bus strobes act only while device select is asserted, except a read strobe rising edge, which clears the flag without select.
`ifndef HOST_PORT_CONSTS_VH
`define HOST_PORT_CONSTS_VH

`define OFS_CTRL       8'h00
`define OFS_OSC_DIV    8'h04
`define OFS_STATUS     8'h08
`define OFS_FIRST_DAC  8'h0C
`define OFS_SECOND_DAC 8'h10
`define OFS_ADC_RESULT 8'h14

`define CTRL_TWOS_BIT  0
`define CTRL_EXTCLK_BIT 1
`define CTRL_RST       2'h0
`define OSC_DIV_RST    16'h0064
`define DAC_RST        8'h00

`define STAT_DONE_BIT  0
`define STAT_BUSY_BIT  1

`define CONV_TICKS     4'h8

`define RESP_OKAY      2'h0
`define RESP_SLVERR    2'h2

`endif

// >>> hw/host_port.v
// The AXI4-Lite interface to the registers and the register offsets were chosen for this implementation.
`timescale 1ns/1ps
`include "host_port_consts.vh"

module host_port #(
  parameter DUAL_DAC = 1
) (
  // System clock and synchronous reset.
  input  wire        CLK_I,
  input  wire        RST_N_I,
  // Device pins from the host side.
  input  wire        DEV_RST_N_I,
  input  wire        CS_N_I,
  input  wire        RD_N_I,
  input  wire        WR_N_I,
  input  wire        DAC_SEL_I,
  input  wire        START_N_I,
  input  wire        EXT_CLK_I,
  input  wire [7:0]  DATA_I,
  output reg  [7:0]  DATA_O,
  output reg         DATA_OE_O,
  output reg         CONV_DONE_N_O,
  output reg         BUSY_N_O,
  // Converter core on the same clock.
  input  wire [7:0]  ADC_CODE_I,
  output reg  [7:0]  FIRST_DAC_O,
  output reg  [7:0]  SECOND_DAC_O,
  // AXI4-Lite write channels.
  input  wire [7:0]  AWADDR_I,
  input  wire        AWVALID_I,
  output reg         AWREADY_O,
  input  wire [31:0] WDATA_I,
  input  wire [3:0]  WSTRB_I,
  input  wire        WVALID_I,
  output reg         WREADY_O,
  output reg  [1:0]  BRESP_O,
  output reg         BVALID_O,
  input  wire        BREADY_I,
  // AXI4-Lite read channels.
  input  wire [7:0]  ARADDR_I,
  input  wire        ARVALID_I,
  output reg         ARREADY_O,
  output reg  [31:0] RDATA_O,
  output reg  [1:0]  RRESP_O,
  output reg         RVALID_O,
  input  wire        RREADY_I
);

  // Pin synchronisers; logic reads stage two and its one-cycle delayed copy.
  reg  [14:0] pin_s1_r;
  reg  [14:0] pin_s2_r;
  reg  [14:0] pin_d_r;

  wire [14:0] pins = {EXT_CLK_I, START_N_I, DAC_SEL_I, WR_N_I,
                      RD_N_I, CS_N_I, DEV_RST_N_I, DATA_I};

  always @(posedge CLK_I) begin
    if (!RST_N_I) begin
      pin_s1_r <= 15'h3F00;
      pin_s2_r <= 15'h3F00;
      pin_d_r  <= 15'h3F00;
    end else begin
      pin_s1_r <= pins;
      pin_s2_r <= pin_s1_r;
      pin_d_r  <= pin_s2_r;
    end
  end

  wire [7:0] bus_data  = pin_s2_r[7:0];
  wire       dev_rst   = ~pin_s2_r[8];
  wire       cs_n      = pin_s2_r[9];
  wire       rd_n      = pin_s2_r[10];
  wire       wr_n      = pin_s2_r[11];
  wire       dac_sel   = pin_s2_r[12];
  wire       start_n   = pin_s2_r[13];
  wire       ext_clk   = pin_s2_r[14];

  wire       cs_rise   = cs_n & ~pin_d_r[9];
  wire       rd_rise   = rd_n & ~pin_d_r[10];
  wire       wr_rise   = wr_n & ~pin_d_r[11];
  wire       wr_sel_d  = ~pin_d_r[9];
  wire       st_fall   = ~start_n & pin_d_r[13];
  wire       ck_fall   = ~ext_clk & pin_d_r[14];
  wire       rdsel     = ~cs_n & ~rd_n;
  wire       rdsel_d   = ~pin_d_r[9] & ~pin_d_r[10];

  // Control registers.
  reg  [1:0]  ctrl_r;
  reg  [15:0] osc_div_r;
  wire        twos = ctrl_r[`CTRL_TWOS_BIT];
  wire        extclk = ctrl_r[`CTRL_EXTCLK_BIT];

  // Format conversion: flipping the sign bit maps twos complement
  // onto the offset binary code that the converter core uses.
  function [7:0] fmt;
    input [7:0] code;
    input       tc;
    begin
      fmt = {code[7] ^ tc, code[6:0]};
    end
  endfunction

  // Host DAC writes.
  reg  [7:0] first_out_reg_r;
  reg  [7:0] second_out_reg_r;

  always @(posedge CLK_I) begin
    if (!RST_N_I || dev_rst) begin
      first_out_reg_r  <= `DAC_RST;
      second_out_reg_r <= `DAC_RST;
    end else if (wr_rise && wr_sel_d) begin
      if (DUAL_DAC != 0 && dac_sel) begin
        second_out_reg_r <= bus_data;
      end else begin
        first_out_reg_r <= bus_data;
      end
    end
  end

  always @(posedge CLK_I) begin
    if (!RST_N_I) begin
      FIRST_DAC_O  <= `DAC_RST;
      SECOND_DAC_O <= `DAC_RST;
    end else begin
      FIRST_DAC_O  <= fmt(first_out_reg_r, twos);
      SECOND_DAC_O <= fmt(second_out_reg_r, twos);
    end
  end

  // Conversion clock tick from the pin or the internal oscillator.
  reg  [15:0] osc_cnt_r;
  reg         osc_tick_r;

  always @(posedge CLK_I) begin
    if (!RST_N_I) begin
      osc_cnt_r  <= 16'h0000;
      osc_tick_r <= 1'b0;
    end else if (osc_cnt_r >= osc_div_r) begin
      osc_cnt_r  <= 16'h0000;
      osc_tick_r <= 1'b1;
    end else begin
      osc_cnt_r  <= osc_cnt_r + 16'h0001;
      osc_tick_r <= 1'b0;
    end
  end

  wire conv_tick = extclk ? ck_fall : osc_tick_r;

  // Conversion sequencer.
  localparam ST_IDLE = 1'b0;
  localparam ST_CONV = 1'b1;

  reg        state_r;
  reg  [3:0] tick_cnt_r;
  reg  [7:0] result_r;
  wire       start_req = st_fall | (rdsel & ~rdsel_d);
  wire       conv_end  = (state_r == ST_CONV) && conv_tick &&
                         (tick_cnt_r == `CONV_TICKS - 4'h1);

  // The reset pin leaves a running conversion alone on purpose.
  always @(posedge CLK_I) begin
    if (!RST_N_I) begin
      state_r    <= ST_IDLE;
      tick_cnt_r <= 4'h0;
      result_r   <= 8'h00;
      BUSY_N_O   <= 1'b1;
    end else begin
      case (state_r)
        ST_IDLE: begin
          if (start_req) begin
            state_r    <= ST_CONV;
            tick_cnt_r <= 4'h0;
            BUSY_N_O   <= 1'b0;
          end
        end
        ST_CONV: begin
          if (conv_end) begin
            state_r  <= ST_IDLE;
            result_r <= ADC_CODE_I;
            BUSY_N_O <= 1'b1;
          end else if (conv_tick) begin
            tick_cnt_r <= tick_cnt_r + 4'h1;
          end
        end
        default: begin
          state_r  <= ST_IDLE;
          BUSY_N_O <= 1'b1;
        end
      endcase
    end
  end

  // Completion flag; a finishing conversion beats a clear in the same cycle.
  always @(posedge CLK_I) begin
    if (!RST_N_I) begin
      CONV_DONE_N_O <= 1'b1;
    end else if (conv_end) begin
      CONV_DONE_N_O <= 1'b0;
    end else if (dev_rst) begin
      CONV_DONE_N_O <= 1'b1;
    end else if (cs_rise || rd_rise) begin
      CONV_DONE_N_O <= 1'b1;
    end
  end

  // Result drive onto the data bus.
  always @(posedge CLK_I) begin
    if (!RST_N_I) begin
      DATA_O    <= 8'h00;
      DATA_OE_O <= 1'b0;
    end else begin
      DATA_O    <= fmt(result_r, twos);
      DATA_OE_O <= rdsel;
    end
  end

  // AXI4-Lite write path.
  reg  [7:0]  awaddr_r;
  reg  [31:0] wdata_r;
  reg  [3:0]  wstrb_r;
  reg         aw_got_r;
  reg         w_got_r;
  wire        wr_commit = aw_got_r & w_got_r & ~BVALID_O;
  wire        wr_ctrl   = wr_commit && awaddr_r == `OFS_CTRL;
  wire        wr_osc    = wr_commit && awaddr_r == `OFS_OSC_DIV;

  always @(posedge CLK_I) begin
    if (!RST_N_I) begin
      awaddr_r  <= 8'h00;
      wdata_r   <= 32'h00000000;
      wstrb_r   <= 4'h0;
      aw_got_r  <= 1'b0;
      w_got_r   <= 1'b0;
      AWREADY_O <= 1'b1;
      WREADY_O  <= 1'b1;
      BVALID_O  <= 1'b0;
      BRESP_O   <= `RESP_OKAY;
    end else begin
      if (AWREADY_O && AWVALID_I) begin
        awaddr_r  <= AWADDR_I;
        aw_got_r  <= 1'b1;
        AWREADY_O <= 1'b0;
      end
      if (WREADY_O && WVALID_I) begin
        wdata_r  <= WDATA_I;
        wstrb_r  <= WSTRB_I;
        w_got_r  <= 1'b1;
        WREADY_O <= 1'b0;
      end
      if (wr_commit) begin
        aw_got_r <= 1'b0;
        w_got_r  <= 1'b0;
        BVALID_O <= 1'b1;
        BRESP_O  <= (wr_ctrl || wr_osc) ? `RESP_OKAY : `RESP_SLVERR;
      end
      if (BVALID_O && BREADY_I) begin
        BVALID_O  <= 1'b0;
        AWREADY_O <= 1'b1;
        WREADY_O  <= 1'b1;
      end
    end
  end

  always @(posedge CLK_I) begin
    if (!RST_N_I) begin
      ctrl_r    <= `CTRL_RST;
      osc_div_r <= `OSC_DIV_RST;
    end else begin
      if (wr_ctrl && wstrb_r[0]) begin
        ctrl_r <= wdata_r[1:0];
      end
      if (wr_osc && wstrb_r[0]) begin
        osc_div_r[7:0] <= wdata_r[7:0];
      end
      if (wr_osc && wstrb_r[1]) begin
        osc_div_r[15:8] <= wdata_r[15:8];
      end
    end
  end

  // AXI4-Lite read path.
  function [32:0] rd_decode;
    input [7:0] addr;
    begin
      case (addr)
        `OFS_CTRL:       rd_decode = {1'b0, 30'h0, ctrl_r};
        `OFS_OSC_DIV:    rd_decode = {1'b0, 16'h0, osc_div_r};
        `OFS_STATUS:     rd_decode = {1'b0, 30'h0, ~BUSY_N_O,
                                      ~CONV_DONE_N_O};
        `OFS_FIRST_DAC:  rd_decode = {1'b0, 24'h0, first_out_reg_r};
        `OFS_SECOND_DAC: rd_decode = {1'b0, 24'h0, second_out_reg_r};
        `OFS_ADC_RESULT: rd_decode = {1'b0, 24'h0, fmt(result_r, twos)};
        default:         rd_decode = {1'b1, 32'h00000000};
      endcase
    end
  endfunction

  wire [32:0] rd_word = rd_decode(ARADDR_I);

  always @(posedge CLK_I) begin
    if (!RST_N_I) begin
      ARREADY_O <= 1'b1;
      RVALID_O  <= 1'b0;
      RDATA_O   <= 32'h00000000;
      RRESP_O   <= `RESP_OKAY;
    end else begin
      if (ARREADY_O && ARVALID_I) begin
        ARREADY_O <= 1'b0;
        RVALID_O  <= 1'b1;
        RDATA_O   <= rd_word[31:0];
        RRESP_O   <= rd_word[32] ? `RESP_SLVERR : `RESP_OKAY;
      end
      if (RVALID_O && RREADY_I) begin
        RVALID_O  <= 1'b0;
        ARREADY_O <= 1'b1;
      end
    end
  end

endmodule

// >>> testbench/host_port_chk_sva.sv
`timescale 1ns/1ps
module host_port_chk (
  // Clock, reset and device pins.
  input wire logic       CLK_I,
  input wire logic       RST_N_I,
  input wire logic       DEV_RST_N_I,
  input wire logic       CS_N_I,
  input wire logic       RD_N_I,
  // Device pin outputs and the two DAC outputs.
  input wire logic       BUSY_N_O,
  input wire logic       CONV_DONE_N_O,
  input wire logic       DATA_OE_O,
  input wire logic [7:0] FIRST_DAC_O,
  input wire logic [7:0] SECOND_DAC_O,
  // Register bus handshakes.
  input wire logic       AWVALID_I,
  input wire logic       AWREADY_O,
  input wire logic       WVALID_I,
  input wire logic       WREADY_O,
  input wire logic       BVALID_O,
  input wire logic       BREADY_I,
  input wire logic       ARVALID_I,
  input wire logic       ARREADY_O,
  input wire logic       RVALID_O
);
  default clocking @(posedge CLK_I); endclocking
  default disable iff (!RST_N_I);
  // Pins pass a two-stage synchroniser, so pin effects are judged after a settled run.
  bvalid_hold_a: assert property (BVALID_O && !BREADY_I |=> BVALID_O)
    else $error("write response dropped");
  bresp_time_a: assert property (AWVALID_I && AWREADY_O && WVALID_I && WREADY_O |-> ##[1:2] BVALID_O)
    else $error("write response late");
  rresp_time_a: assert property (ARVALID_I && ARREADY_O |-> ##[1:2] RVALID_O)
    else $error("read response late");
  ready_low_a: assert property (BVALID_O |-> !AWREADY_O && !WREADY_O)
    else $error("ready during response");
  oe_on_a: assert property ((!CS_N_I && !RD_N_I) [*5] |-> DATA_OE_O)
    else $error("bus not driven on read");
  oe_off_a: assert property ((CS_N_I || RD_N_I) [*5] |-> !DATA_OE_O)
    else $error("bus driven while unselected");
  flag_rst_a: assert property (!DEV_RST_N_I [*5] |-> CONV_DONE_N_O)
    else $error("flag low in reset");
  dac_clr_a: assert property (!DEV_RST_N_I [*6] |-> FIRST_DAC_O == 8'h00 && SECOND_DAC_O == 8'h00)
    else $error("dac not cleared");
  flag_fall_a: assert property ($fell(CONV_DONE_N_O) |-> $rose(BUSY_N_O))
    else $error("flag fell without conversion end");
  flag_clear_a: assert property ($rose(CS_N_I) || $rose(RD_N_I) |-> ##[1:5] CONV_DONE_N_O)
    else $error("flag not cleared");
endmodule
bind host_port host_port_chk host_port_chk_i (
  .CLK_I         (CLK_I),
  .RST_N_I       (RST_N_I),
  .DEV_RST_N_I   (DEV_RST_N_I),
  .CS_N_I        (CS_N_I),
  .RD_N_I        (RD_N_I),
  .BUSY_N_O      (BUSY_N_O),
  .CONV_DONE_N_O (CONV_DONE_N_O),
  .DATA_OE_O     (DATA_OE_O),
  .FIRST_DAC_O   (FIRST_DAC_O),
  .SECOND_DAC_O  (SECOND_DAC_O),
  .AWVALID_I     (AWVALID_I),
  .AWREADY_O     (AWREADY_O),
  .WVALID_I      (WVALID_I),
  .WREADY_O      (WREADY_O),
  .BVALID_O      (BVALID_O),
  .BREADY_I      (BREADY_I),
  .ARVALID_I     (ARVALID_I),
  .ARREADY_O     (ARREADY_O),
  .RVALID_O      (RVALID_O)
);

// >>> testbench/host_pin_model.sv
`timescale 1ns/1ps
module host_pin_model (
  input  wire logic       clk_i,
  input  wire logic [7:0] bus_i,
  output logic            cs_n_o = 1'b1,
  output logic            rd_n_o = 1'b1,
  output logic            wr_n_o = 1'b1,
  output logic            sel_o = 1'b0,
  output logic [7:0]      d_o = 8'h00,
  output logic            den_o = 1'b0
);
  // Each strobe level is held at least four cycles so the synchroniser always sees it.
  task automatic pwr(input logic cs, input logic sel, input logic [7:0] d);
    sel_o <= sel;
    d_o <= d;
    den_o <= 1'b1;
    cs_n_o <= !cs;
    repeat (4) @(posedge clk_i);
    wr_n_o <= 1'b0;
    repeat (4) @(posedge clk_i);
    wr_n_o <= 1'b1;
    repeat (4) @(posedge clk_i);
    cs_n_o <= 1'b1;
    den_o <= 1'b0;
    // Select stays high long enough that back-to-back writes keep the minimum level time.
    repeat (4) @(posedge clk_i);
  endtask
  task automatic prd(output logic [7:0] d);
    cs_n_o <= 1'b0;
    rd_n_o <= 1'b0;
    repeat (6) @(posedge clk_i);
    d = bus_i;
    cs_n_o <= 1'b1;
    rd_n_o <= 1'b1;
    repeat (4) @(posedge clk_i);
  endtask
endmodule

// >>> testbench/adc_dac_host_bus_port_test.sv
`timescale 1ns/1ps
`include "host_port_consts.vh"
module adc_dac_host_bus_port_test;
  logic        clk = 1'b0;
  logic        rst_n = 1'b0;
  logic        dev_rst_n = 1'b1;
  logic        start_n = 1'b1;
  logic        ext_clk = 1'b0;
  logic [7:0]  adc = 8'h00;
  logic [7:0]  awa = 8'h00;
  logic [7:0]  ara = 8'h00;
  logic [31:0] wd = 32'h0;
  logic        awv = 1'b0, wv = 1'b0, br = 1'b0, arv = 1'b0, rr = 1'b0;
  wire         cs_n, rd_n, wr_n, sel, den, oe, conv_n, busy_n, awr, wrdy, bv, arr, rv;
  wire [7:0]   dout, dhost, bus, dac_a, dac_b;
  wire [1:0]   bresp, rresp;
  wire [31:0]  rdata;
  int          miscompares = 0;
  int          samples_checked = 0;
  // A released bus shows the inverse of the host's last driven value, never a kind default.
  assign bus = oe ? dout : (den ? dhost : ~dhost);
  host_port host_port_i (
    .CLK_I(clk), .RST_N_I(rst_n), .DEV_RST_N_I(dev_rst_n), .CS_N_I(cs_n), .RD_N_I(rd_n),
    .WR_N_I(wr_n), .DAC_SEL_I(sel), .START_N_I(start_n), .EXT_CLK_I(ext_clk), .DATA_I(bus),
    .DATA_O(dout), .DATA_OE_O(oe), .CONV_DONE_N_O(conv_n), .BUSY_N_O(busy_n), .ADC_CODE_I(adc),
    .FIRST_DAC_O(dac_a), .SECOND_DAC_O(dac_b), .AWADDR_I(awa), .AWVALID_I(awv), .AWREADY_O(awr),
    .WDATA_I(wd), .WSTRB_I(4'hF), .WVALID_I(wv), .WREADY_O(wrdy), .BRESP_O(bresp), .BVALID_O(bv),
    .BREADY_I(br), .ARADDR_I(ara), .ARVALID_I(arv), .ARREADY_O(arr), .RDATA_O(rdata),
    .RRESP_O(rresp), .RVALID_O(rv), .RREADY_I(rr)
  );
  host_pin_model host_pin_model_i (
    .clk_i(clk), .bus_i(bus), .cs_n_o(cs_n), .rd_n_o(rd_n), .wr_n_o(wr_n), .sel_o(sel),
    .d_o(dhost), .den_o(den)
  );
  initial begin
    forever #2.5 clk = ~clk;
  end
  initial begin
    forever #20 ext_clk = ~ext_clk;
  end
  task cmp(input string nm, input logic [31:0] e, input logic [31:0] g);
    samples_checked++;
    if (g !== e) begin
      miscompares++;
      $display("MISMATCH %s expected %h seen %h", nm, e, g);
    end
  endtask
  task results;
    if (miscompares == 0 && samples_checked > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask
  task axw(input logic [7:0] a, input logic [31:0] d, input logic [1:0] r);
    int n;
    logic [1:0] g;
    awa <= a;
    wd <= d;
    awv <= 1'b1;
    wv <= 1'b1;
    br <= 1'b1;
    for (n = 0; n < 50; n++) begin
      @(posedge clk);
      if (awr) awv <= 1'b0;
      if (wrdy) wv <= 1'b0;
      if (bv) break;
    end
    g = bresp;
    br <= 1'b0;
    @(posedge clk);
    cmp("bresp", r, g);
    if (n == 50) begin
      miscompares++;
      results;
    end
  endtask
  task axr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] r);
    int n;
    logic [31:0] g;
    logic [1:0] s;
    ara <= a;
    arv <= 1'b1;
    rr <= 1'b1;
    for (n = 0; n < 50; n++) begin
      @(posedge clk);
      if (arr) arv <= 1'b0;
      if (rv) break;
    end
    g = rdata;
    s = rresp;
    rr <= 1'b0;
    @(posedge clk);
    cmp("rdata", d, g);
    cmp("rresp", r, s);
    if (n == 50) begin
      miscompares++;
      results;
    end
  endtask
  task wt(input bit busy);
    int n;
    for (n = 0; n < 400 && (busy ? busy_n !== 1'b1 : conv_n !== 1'b0); n++) @(posedge clk);
    if (n == 400) begin
      miscompares++;
      results;
    end
  endtask
  task conv(input logic [7:0] code, input logic [7:0] e);
    logic [7:0] g;
    adc <= code;
    wt(1'b1);
    start_n <= 1'b0;
    repeat (4) @(posedge clk);
    start_n <= 1'b1;
    axr(`OFS_STATUS, 32'h00000002, `RESP_OKAY);
    wt(1'b0);
    host_pin_model_i.prd(g);
    cmp("result", e, g);
    repeat (6) @(posedge clk);
    cmp("done_n", 1, conv_n);
  endtask
  initial begin
    repeat (2) @(posedge clk);
    rst_n <= 1'b1;
    repeat (3) @(posedge clk);
    axr(`OFS_CTRL, 0, `RESP_OKAY);
    axr(`OFS_OSC_DIV, `OSC_DIV_RST, `RESP_OKAY);
    axw(`OFS_OSC_DIV, 2, `RESP_OKAY);
    axr(`OFS_OSC_DIV, 2, `RESP_OKAY);
    axw(`OFS_FIRST_DAC, 5, `RESP_SLVERR);
    axr(8'h18, 0, `RESP_SLVERR);
    host_pin_model_i.pwr(1'b1, 1'b0, 8'hA5);
    host_pin_model_i.pwr(1'b1, 1'b1, 8'h3C);
    host_pin_model_i.pwr(1'b0, 1'b0, 8'hFF);
    cmp("first", 8'hA5, dac_a);
    cmp("second", 8'h3C, dac_b);
    axr(`OFS_FIRST_DAC, 8'hA5, `RESP_OKAY);
    axr(`OFS_SECOND_DAC, 8'h3C, `RESP_OKAY);
    conv(8'hC3, 8'hC3);
    wt(1'b1);
    cmp("flag_low", 0, conv_n);
    axr(`OFS_STATUS, 32'h00000001, `RESP_OKAY);
    axr(`OFS_ADC_RESULT, 8'hC3, `RESP_OKAY);
    dev_rst_n <= 1'b0;
    repeat (8) @(posedge clk);
    cmp("rst_flag", 1, conv_n);
    cmp("rst_first", 0, dac_a);
    cmp("rst_second", 0, dac_b);
    axr(`OFS_STATUS, 32'h00000000, `RESP_OKAY);
    dev_rst_n <= 1'b1;
    axw(`OFS_CTRL, 3, `RESP_OKAY);
    host_pin_model_i.pwr(1'b1, 1'b0, 8'h05);
    cmp("twos_first", 8'h85, dac_a);
    conv(8'h81, 8'h01);
    results;
  end
endmodule
